// File: include/msc_pkg.sv
// System-control constants: register map, vectors, timing, field positions.
// Assumes a 10 MHz core clock and a 5-bit special-register address.
package msc_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int AW = 5;
    localparam int DW = 4;
    // Register offsets
    localparam logic [4:0] ADR_STATUS = 5'h00;
    localparam logic [4:0] ADR_LOW = 5'h08;
    localparam logic [4:0] ADR_ACTL = 5'h09;
    localparam logic [4:0] ADR_MID = 5'h0A;
    localparam logic [4:0] ADR_HIGH = 5'h0B;
    localparam logic [4:0] ADR_LVCTL = 5'h13;
    localparam logic [4:0] ADR_LVSEL = 5'h14;
    localparam logic [4:0] ADR_DROMH = 5'h1D;
    // Field positions
    localparam int B_ZF = 0;
    localparam int B_CF = 1;
    localparam int B_IRQF = 2;
    localparam int B_AEN = 0;
    localparam int B_GIE = 1;
    localparam int B_LVEN = 0;
    localparam int B_LVFLG = 1;
    // Program entry points
    localparam logic [11:0] VEC_RESET = 12'h000;
    localparam logic [11:0] VEC_WAKE = 12'h004;
    localparam logic [11:0] VEC_INT = 12'h008;
    // Audio rates and period counts
    localparam int RATE_HZ = 32768;
    localparam int RATE2_HZ = 65536;
    localparam int PW = 9;
    localparam logic [8:0] PER_NORM = 9'(CLK_HZ / RATE_HZ);
    localparam logic [8:0] PER_DBL = 9'(CLK_HZ / RATE2_HZ);
    // Restart delay after wake or reset
    localparam int RESTART_CYCLES = 64;
    localparam logic [5:0] RESTART_LAST = 6'(RESTART_CYCLES - 1);
    // Watchdog length in cycles and counter width
    localparam int WDT_LEN = 256 * 256 * 16;
    localparam int WDT_W = 21;
    localparam int SW = 12;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HALT = 2'b01,
        ST_RESTART = 2'b10
    } msc_state_t;
endpackage

// File: rtl/msc_sys_ctrl.sv
// System control of a 4-bit speech controller: vectors, halt, wake, watchdog,
// audio interrupt, supply detect and audio sample assembly.
// Assumes core, pins and comparator sit outside; options are static straps.
`timescale 1ns/1ps
`default_nettype none
module msc_sys_ctrl
    import msc_pkg::*;
#(
    parameter int WDT_CYCLES = WDT_LEN
)(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [3:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [3:0] reg_rdata_o,
    input wire logic halt_exec_i,
    input wire logic instr_boundary_i,
    input wire logic irq_return_i,
    input wire logic alu_flag_we_i,
    input wire logic alu_carry_i,
    input wire logic alu_zero_i,
    input wire logic [3:0] wake_port_pins_i,
    input wire logic [3:0] wake_enable_i,
    input wire logic wdt_enable_i,
    input wire logic double_rate_option_i,
    input wire logic dac_output_option_i,
    input wire logic ten_bit_option_i,
    input wire logic twelve_bit_option_i,
    input wire logic supply_below_i,
    output logic pc_load_o,
    output logic [11:0] pc_vector_o,
    output logic core_run_o,
    output logic sys_clk_en_o,
    output logic irq_req_o,
    output logic carry_flag_o,
    output logic zero_flag_o,
    output logic wdt_reset_o,
    output logic low_supply_detect_enable_o,
    output logic [3:0] supply_level_o,
    output logic [11:0] sample_word_o,
    output logic sample_load_o,
    output logic [11:0] dac_data_o,
    output logic speaker_out_plus_o,
    output logic speaker_out_minus_o,
    output logic speaker_oe_o
);

    typedef struct packed {
        msc_state_t st;
        logic [5:0] cnt;
        logic [WDT_W-1:0] wdt;
        logic [PW-1:0] per;
        logic irqf;
        logic cf;
        logic zf;
        logic gie;
        logic aen;
        logic lv_en;
        logic [3:0] lv_sel;
        logic [3:0] low;
        logic [3:0] mid;
        logic [3:0] high;
        logic [SW-1:0] sample;
        logic ld;
        logic in_svc;
        logic pc_load;
        logic [11:0] vec;
        logic run;
        logic irq;
        logic [3:0] rdata;
        logic wdt_rst;
        logic spk_p;
        logic spk_n;
        logic spk_oe;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [3:0] pin_prev;
        logic cmp_s1;
        logic cmp_s2;
        logic lv_flag;
        logic [11:0] dac;
        logic clk_en;
    } msc_regs_t;

    localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);

    // Value of all state after any reset
    function automatic msc_regs_t reset_val();
        msc_regs_t r;
        r = '0;
        r.st = ST_RESTART;
        r.vec = VEC_RESET;
        r.spk_oe = 1'b1;
        r.clk_en = 1'b1;
        return r;
    endfunction

    // Assemble the signed sample from high and mid, plus low in 10- and 12-bit modes
    function automatic logic [SW-1:0] pack_sample(
        input logic [3:0] hi,
        input logic [3:0] md,
        input logic [3:0] lo,
        input logic ten,
        input logic twelve
    );
        logic [SW-1:0] s;
        s = '0;
        if (twelve)
        begin
            s = {hi, md, lo};
        end
        else if (ten)
        begin
            s = {2'h0, hi, md, lo[3:2]};
        end
        else
        begin
            s = {4'h0, hi, md};
        end
        return s;
    endfunction

    msc_regs_t q;
    msc_regs_t d;
    logic [PW-1:0] per_last;
    logic wake_edge;
    logic wdt_expire;
    logic [6:0] mag;

    // Period select, wake edge and watchdog expiry
    always_comb
    begin
        per_last = (double_rate_option_i ? PER_DBL : PER_NORM) - 9'h001;
        wake_edge = |(q.pin_s2 & ~q.pin_prev & wake_enable_i);
        wdt_expire = wdt_enable_i && (q.wdt == WDT_LAST);
        mag = {q.high[2:0], q.mid};
    end

    // Next-state logic for the whole block
    always_comb
    begin
        d = q;
        d.pc_load = 1'b0;
        d.ld = 1'b0;
        d.wdt_rst = 1'b0;
        d.rdata = 4'h0;
        // Pin and comparator synchronisers
        d.pin_s1 = wake_port_pins_i;
        d.pin_s2 = q.pin_s1;
        d.pin_prev = q.pin_s2;
        d.cmp_s1 = supply_below_i;
        d.cmp_s2 = q.cmp_s1;
        d.lv_flag = q.lv_en & q.cmp_s2;

        // Register reads, one cycle later
        if (reg_rd_i)
        begin
            if (reg_addr_i == ADR_STATUS)
            begin
                d.rdata = {1'b0, q.irqf, q.cf, q.zf};
            end
            else if (reg_addr_i == ADR_ACTL)
            begin
                d.rdata = {2'h0, q.gie, q.aen};
            end
            else if (reg_addr_i == ADR_LVCTL)
            begin
                d.rdata = {2'h0, q.lv_flag, q.lv_en};
            end
            else if (reg_addr_i == ADR_LVSEL)
            begin
                d.rdata = q.lv_sel;
            end
            else
            begin
                d.rdata = 4'h0;
            end
        end

        // Core flag updates
        if (alu_flag_we_i)
        begin
            d.cf = alu_carry_i;
            d.zf = alu_zero_i;
        end

        // Register writes, ignored while halted
        if (reg_wr_i && q.st != ST_HALT)
        begin
            if (reg_addr_i == ADR_STATUS)
            begin
                d.cf = reg_wdata_i[B_CF];
                d.zf = reg_wdata_i[B_ZF];
                if (!reg_wdata_i[B_IRQF])
                begin
                    d.irqf = 1'b0;
                end
            end
            else if (reg_addr_i == ADR_LOW)
            begin
                d.low = reg_wdata_i;
            end
            else if (reg_addr_i == ADR_ACTL)
            begin
                d.gie = reg_wdata_i[B_GIE];
                d.aen = reg_wdata_i[B_AEN];
            end
            else if (reg_addr_i == ADR_MID)
            begin
                d.mid = reg_wdata_i;
            end
            else if (reg_addr_i == ADR_HIGH)
            begin
                d.high = reg_wdata_i;
            end
            else if (reg_addr_i == ADR_LVCTL)
            begin
                d.lv_en = reg_wdata_i[B_LVEN];
            end
            else if (reg_addr_i == ADR_LVSEL)
            begin
                d.lv_sel = reg_wdata_i;
            end
            else if (reg_addr_i == ADR_DROMH)
            begin
                d.wdt = '0;
            end
        end

        // Watchdog runs only while the clock runs
        if (q.st != ST_HALT && wdt_enable_i && !(reg_wr_i && reg_addr_i == ADR_DROMH))
        begin
            d.wdt = q.wdt + WDT_W'(1);
        end

        // Audio output period; end of cycle loads sample and sets flag
        if (q.aen && q.st != ST_HALT)
        begin
            if (q.per == per_last)
            begin
                d.per = '0;
                d.irqf = 1'b1;
                d.ld = 1'b1;
                d.sample = pack_sample(q.high, q.mid, q.low, ten_bit_option_i, twelve_bit_option_i);
            end
            else
            begin
                d.per = q.per + 9'h001;
            end
        end
        else
        begin
            d.per = '0;
        end

        // Speaker drive: sign picks the pin, magnitude sets pulse width
        if (q.aen && !dac_output_option_i && q.per < {2'h0, mag})
        begin
            d.spk_p = ~q.high[3];
            d.spk_n = q.high[3];
        end
        else
        begin
            d.spk_p = 1'b0;
            d.spk_n = 1'b0;
        end
        // Interrupt request level
        d.irq = q.gie & q.irqf;
        if (irq_return_i)
        begin
            d.in_svc = 1'b0;
        end

        // Sequencing of run, halt and restart
        case (q.st)
            ST_RUN:
            begin
                d.run = 1'b1;
                if (halt_exec_i)
                begin
                    d.st = ST_HALT;
                    d.run = 1'b0;
                    d.vec = VEC_WAKE;
                    d.pc_load = 1'b1;
                    d.wdt = '0;
                    d.aen = 1'b0;
                    d.spk_p = 1'b0;
                    d.spk_n = 1'b0;
                end
                else if (instr_boundary_i && q.gie && q.irqf && !q.in_svc)
                begin
                    d.vec = VEC_INT;
                    d.pc_load = 1'b1;
                    d.in_svc = 1'b1;
                end
            end
            ST_HALT:
            begin
                d.run = 1'b0;
                if (wake_edge)
                begin
                    d.st = ST_RESTART;
                    d.cnt = '0;
                    d.wdt = '0;
                end
            end
            ST_RESTART:
            begin
                d.run = 1'b0;
                if (q.cnt == RESTART_LAST)
                begin
                    d.st = ST_RUN;
                    d.run = 1'b1;
                    d.pc_load = 1'b1;
                end
                else
                begin
                    d.cnt = q.cnt + 6'h01;
                end
            end
            default:
            begin
                d.st = ST_RESTART;
                d.cnt = '0;
            end
        endcase

        // Watchdog overflow restarts the whole system
        if (wdt_expire)
        begin
            d = reset_val();
            d.wdt_rst = 1'b1;
        end

        // Converter data, clock enable and pin enable follow the next state
        d.dac = dac_output_option_i ? d.sample : 12'h000;
        d.clk_en = (d.st != ST_HALT);
        d.spk_oe = (d.st != ST_HALT);
    end

    // State register; reset beats wake, enable freezes all
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            q <= reset_val();
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_o = q.rdata;
    assign pc_load_o = q.pc_load;
    assign pc_vector_o = q.vec;
    assign core_run_o = q.run;
    assign sys_clk_en_o = q.clk_en;
    assign irq_req_o = q.irq;
    assign carry_flag_o = q.cf;
    assign zero_flag_o = q.zf;
    assign wdt_reset_o = q.wdt_rst;
    assign low_supply_detect_enable_o = q.lv_en;
    assign supply_level_o = q.lv_sel;
    assign sample_word_o = q.sample;
    assign sample_load_o = q.ld;
    assign dac_data_o = q.dac;
    assign speaker_out_plus_o = q.spk_p;
    assign speaker_out_minus_o = q.spk_n;
    assign speaker_oe_o = q.spk_oe;

endmodule
`default_nettype wire

// File: bench/msc_checker.sv
// Checker for the system-control block: halt, restart, interrupt, watchdog and audio pins.
// Bound to msc_sys_ctrl; the clock enable is held high throughout.
`timescale 1ns/1ps
`default_nettype none
module msc_checker
    import msc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic halt_exec_i,
    input wire logic instr_boundary_i,
    input wire logic dac_output_option_i,
    input wire logic pc_load_o,
    input wire logic [11:0] pc_vector_o,
    input wire logic core_run_o,
    input wire logic sys_clk_en_o,
    input wire logic wdt_reset_o,
    input wire logic [11:0] sample_word_o,
    input wire logic sample_load_o,
    input wire logic [11:0] dac_data_o,
    input wire logic speaker_out_plus_o,
    input wire logic speaker_out_minus_o,
    input wire logic speaker_oe_o
);
    logic [7:0] wait_q;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // Restart cycles before the core runs
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || core_run_o || !sys_clk_en_o)
        begin
            wait_q <= 8'h00;
        end
        else if (wait_q != 8'hFF)
        begin
            wait_q <= wait_q + 8'h01;
        end
    end
    // Halt entry, restart length and entry vectors
    a_halt_entry: assert property (halt_exec_i && core_run_o |=>
        pc_load_o && pc_vector_o == VEC_WAKE && !core_run_o && !sys_clk_en_o)
        else $error("halt entry wrong");
    a_halt_pins: assert property (!sys_clk_en_o && $past(!sys_clk_en_o) |->
        !speaker_oe_o && !speaker_out_plus_o && !speaker_out_minus_o)
        else $error("speaker driven while halted");
    a_restart_len: assert property ($rose(core_run_o) |-> wait_q >= 8'h3F && wait_q <= 8'h41)
        else $error("restart length wrong");
    a_int_entry: assert property (pc_load_o && pc_vector_o == VEC_INT |->
        $past(instr_boundary_i) && core_run_o)
        else $error("interrupt entry without request point");
    a_wdt_restart: assert property (wdt_reset_o |=>
        !wdt_reset_o && !core_run_o && pc_vector_o == VEC_RESET)
        else $error("watchdog reset wrong");
    // Audio output path
    a_load_pulse: assert property (sample_load_o |=> !sample_load_o [*8])
        else $error("sample load pulse too long");
    a_dac_route: assert property (dac_data_o == ($past(dac_output_option_i) ? sample_word_o : 12'h000))
        else $error("converter data wrong");
    a_dac_quiet: assert property (dac_output_option_i && $past(dac_output_option_i) |->
        !speaker_out_plus_o && !speaker_out_minus_o)
        else $error("speaker pulse in converter mode");
    a_sign_excl: assert property (!(speaker_out_plus_o && speaker_out_minus_o))
        else $error("both speaker pins active");
    c_int: cover property (pc_load_o && pc_vector_o == VEC_INT);
    c_wake: cover property (pc_load_o && pc_vector_o == VEC_WAKE);
    c_wdt: cover property (wdt_reset_o);
    c_load: cover property (sample_load_o);
endmodule
`default_nettype wire

// File: bench/msc_sys_ctrl_bench.sv
// Bench for msc_sys_ctrl: registers, sample assembly, rates, interrupt, halt, wake, watchdog.
// Needs msc_pkg and the checker compiled first; watchdog shortened to 200 cycles.
`timescale 1ns/1ps
`default_nettype none
module msc_sys_ctrl_bench
    import msc_pkg::*;
;
    localparam int WDT_N = 200;
    logic clk, rst, wr, rd, hlt, ib, ir, fwe, cy, zr, wde, dbl, dac, ten, twl, blw;
    logic pcl, run, cke, wdr, lve, sld, spp, spm, spoe, irq, cfl, zfl;
    logic [4:0] addr;
    logic [3:0] wd, pins, wen, rdat, lvl;
    logic [11:0] vec, sw, dd;
    logic [11:0] exp_w [3] = '{12'h0A5, 12'h297, 12'hA5C};
    int num_errors = 0;
    int checked = 0;
    int n_int = 0;
    int n_wdr = 0;
    int n;
    msc_sys_ctrl #(.WDT_CYCLES(WDT_N)) msc_sys_ctrl_inst (
        .core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdat), .halt_exec_i(hlt), .instr_boundary_i(ib), .irq_return_i(ir),
        .alu_flag_we_i(fwe), .alu_carry_i(cy), .alu_zero_i(zr), .wake_port_pins_i(pins), .wake_enable_i(wen),
        .wdt_enable_i(wde), .double_rate_option_i(dbl), .dac_output_option_i(dac), .ten_bit_option_i(ten),
        .twelve_bit_option_i(twl), .supply_below_i(blw), .pc_load_o(pcl), .pc_vector_o(vec), .core_run_o(run),
        .sys_clk_en_o(cke), .irq_req_o(irq), .carry_flag_o(cfl), .zero_flag_o(zfl), .wdt_reset_o(wdr),
        .low_supply_detect_enable_o(lve), .supply_level_o(lvl), .sample_word_o(sw), .sample_load_o(sld),
        .dac_data_o(dd), .speaker_out_plus_o(spp), .speaker_out_minus_o(spm), .speaker_oe_o(spoe));
    // Compare, count and report
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One-cycle register accesses
    task automatic wrr(input logic [4:0] a, input logic [3:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [4:0] a, input logic [3:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(16'(rdat), 16'(e));
    endtask
    // Bounded wait for a level, counting edges
    task automatic wait_hi(ref logic s, input int lim, output int c);
        c = 0;
        while (s !== 1'b1 && c < lim)
        begin
            @(posedge clk);
            #1;
            c++;
        end
        chk(16'(s), 16'h0001);
    endtask
    // Clock and event monitors
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (pcl === 1'b1 && vec === VEC_INT) n_int++;
        if (wdr === 1'b1) n_wdr++;
    end
    initial
    begin
        #(100 * 20000);
        num_errors++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        {wr, rd, hlt, ib, ir, fwe, cy, zr, wde, dbl, dac, ten, twl, blw} = '0;
        {addr, wd, pins} = '0;
        wen = 4'h2;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (63) @(posedge clk);
        #1;
        chk(16'(run), 16'h0000);
        @(posedge clk);
        #1;
        chk(16'({pcl, run, vec}), 16'({2'b11, VEC_RESET}));
        rdr(ADR_LVCTL, 4'h0);
        rdr(ADR_ACTL, 4'h0);
        rdr(ADR_LVSEL, 4'h0);
        for (int i = 0; i < 16; i++)
        begin
            wrr(ADR_LVSEL, 4'(i));
            rdr(ADR_LVSEL, 4'(i));
            chk(16'(lvl), 16'(i));
        end
        @(posedge clk);
        blw <= 1'b1;
        wrr(ADR_LVCTL, 4'hF);
        repeat (4) @(posedge clk);
        rdr(ADR_LVCTL, 4'h3);
        chk(16'(lve), 16'h0001);
        blw <= 1'b0;
        repeat (4) @(posedge clk);
        rdr(ADR_LVCTL, 4'h1);
        rdr(5'h1E, 4'h0);
        rdr(ADR_MID, 4'h0);
        wrr(ADR_HIGH, 4'hA);
        wrr(ADR_MID, 4'h5);
        wrr(ADR_LOW, 4'hC);
        wrr(ADR_ACTL, 4'h1);
        // Sample widths 8, 10 and 12
        for (int m = 0; m < 3; m++)
        begin
            @(posedge clk);
            ten <= (m == 1);
            twl <= (m == 2);
            repeat (2) @(posedge clk);
            #1;
            wait_hi(sld, 700, n);
            chk(16'(sw), 16'(exp_w[m]));
        end
        @(posedge clk);
        dac <= 1'b1;
        @(posedge clk);
        #1;
        chk(16'(dd), 16'(exp_w[2]));
        @(posedge clk);
        dac <= 1'b0;
        // Period of the audio event at both rates
        for (int r = 0; r < 2; r++)
        begin
            @(posedge clk);
            dbl <= r[0];
            repeat (2) @(posedge clk);
            #1;
            wait_hi(sld, 700, n);
            @(posedge clk);
            #1;
            wait_hi(sld, 700, n);
            chk(16'(n + 1), 16'(r == 0 ? PER_NORM : PER_DBL));
        end
        @(posedge clk);
        dbl <= 1'b0;
        ib <= 1'b1;
        repeat (10) @(posedge clk);
        chk(16'(n_int), 16'h0000);
        rdr(ADR_STATUS, 4'h4);
        wrr(ADR_ACTL, 4'h3);
        wait_hi(pcl, 20, n);
        chk(16'(vec), 16'(VEC_INT));
        chk(16'(irq), 16'h0001);
        @(posedge clk);
        ib <= 1'b0;
        ir <= 1'b1;
        fwe <= 1'b1;
        cy <= 1'b1;
        @(posedge clk);
        ir <= 1'b0;
        fwe <= 1'b0;
        wrr(ADR_STATUS, 4'h2);
        rdr(ADR_STATUS, 4'h2);
        chk(16'({cfl, zfl}), 16'h0002);
        chk(16'(n_int), 16'h0001);
        // Halt, refused writes, wake by an enabled pin only
        @(posedge clk);
        hlt <= 1'b1;
        @(posedge clk);
        hlt <= 1'b0;
        #1;
        chk(16'({pcl, run, cke, vec}), 16'({3'b100, VEC_WAKE}));
        chk(16'(spoe), 16'h0000);
        rdr(ADR_ACTL, 4'h2);
        wrr(ADR_LVSEL, 4'h5);
        @(posedge clk);
        pins <= 4'h1;
        repeat (10) @(posedge clk);
        #1;
        chk(16'(run), 16'h0000);
        @(posedge clk);
        pins <= 4'h3;
        wait_hi(run, 100, n);
        chk(16'(vec), 16'(VEC_WAKE));
        chk(16'(n >= 64 && n <= 70), 16'h0001);
        rdr(ADR_LVSEL, 4'hF);
        // Watchdog kept alive, then left to expire
        @(posedge clk);
        wde <= 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            repeat (150) @(posedge clk);
            wrr(ADR_DROMH, 4'h0);
        end
        chk(16'(n_wdr), 16'h0000);
        #1;
        wait_hi(wdr, 300, n);
        chk(16'(n >= WDT_N - 5 && n <= WDT_N + 5), 16'h0001);
        wait_hi(run, 100, n);
        rdr(ADR_LVSEL, 4'h0);
        finish_test();
    end
endmodule
bind msc_sys_ctrl msc_checker msc_checker_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .halt_exec_i(halt_exec_i), .instr_boundary_i(instr_boundary_i), .dac_output_option_i(dac_output_option_i),
    .pc_load_o(pc_load_o), .pc_vector_o(pc_vector_o), .core_run_o(core_run_o), .sys_clk_en_o(sys_clk_en_o),
    .wdt_reset_o(wdt_reset_o), .sample_word_o(sample_word_o), .sample_load_o(sample_load_o),
    .dac_data_o(dac_data_o), .speaker_out_plus_o(speaker_out_plus_o), .speaker_out_minus_o(speaker_out_minus_o),
    .speaker_oe_o(speaker_oe_o));
`default_nettype wire
